// ---- pkg/l1_protect_params.svh ----
// Constants for the level-one RAM protection block
`ifndef L1_PROTECT_PARAMS_SVH
`define L1_PROTECT_PARAMS_SVH
`define L1P_DATA_W      64
`define L1P_CODE_W      16
`define L1P_ADDR_W      16
`define L1P_TAG_W       24
`define L1P_E64_NBITS   64
`define L1P_E32_NBITS   32
`define L1P_RETRY_MIN   9
`define L1P_RETRY_WAIT  (`L1P_RETRY_MIN - 3)
`define L1P_RST_DATA    64'h0000_0000_0000_0000
`define L1P_RST_CODE    16'h0000
`endif

// ---- pkg/l1_protect_pkg.sv ----
// Types shared by the level-one RAM protection block
`include "l1_protect_params.svh"
package l1_protect_pkg;
	typedef enum logic [1:0] {SCH_PARITY, SCH_ECC32, SCH_ECC64} scheme_t;
	typedef struct packed {
		logic                    valid;
		logic                    write;
		logic                    from_slave;
		logic [7:0]              be;
		logic [`L1P_ADDR_W-1:0]  addr;
		logic [`L1P_DATA_W-1:0]  wdata;
	} req_t;
	typedef struct packed {
		logic                    valid;
		logic                    corr_err;
		logic                    uncorr_err;
		logic                    ext_err;
		logic [`L1P_DATA_W-1:0]  rdata;
	} rsp_t;
	typedef struct packed {
		logic [`L1P_DATA_W-1:0]  data;
		logic                    ce;
		logic                    ue;
	} chk_t;
endpackage

// ---- hdl/l1_ram_protect.sv ----
// Parity / SEC-DED protection between the L1 access paths and the RAM arrays
`timescale 1ns/1ps
`include "l1_protect_params.svh"

// What this block does
// - Parity mode: one parity bit per byte
// - Parity flags byte errors, never corrects
// - Odd or even parity from tie-off input
// - ECC code stored per aligned 32/64-bit chunk
// - ECC corrects single, detects double errors
// - Triple errors may be miscorrected
// - 64-bit chunks carry eight code bits
// - 32-bit chunks carry seven bits, fourteen total
// - Each word of doubleword checked independently
// - One doubleword generated or checked per cycle
// - Every read recomputed, compared, flagged or corrected
// - Scheme by parameter, enable/correct at runtime
// - RAM external error input reported per transfer
// - Tag/dirty entries protected with same code
// - Partial chunk writes use read-modify-write
// - Retry writes back, costs nine extra cycles
// - Slave reads inline, core reads retry
module l1_ram_protect #(
	parameter l1_protect_pkg::scheme_t SCHEME = l1_protect_pkg::SCH_ECC64
) (
	input  wire logic                          clk,
	input  wire logic                          rst_b,
	input  wire logic                          parity_odd,
	input  wire logic                          check_en,
	input  wire logic                          correct_en,
	input  wire l1_protect_pkg::req_t          req,
	output logic                               req_ready,
	output l1_protect_pkg::rsp_t               rsp,
	output logic                               ram_en,
	output logic                               ram_we,
	output logic [7:0]                         ram_be,
	output logic [`L1P_ADDR_W-1:0]             ram_addr,
	output logic [`L1P_DATA_W-1:0]             ram_wdata,
	output logic [`L1P_CODE_W-1:0]             ram_wcode,
	input  wire logic [`L1P_DATA_W-1:0]        ram_rdata,
	input  wire logic [`L1P_CODE_W-1:0]        ram_rcode,
	input  wire logic                          ram_ext_err,
	input  wire logic [`L1P_TAG_W-1:0]         tag_wdata,
	output logic [`L1P_CODE_W-1:0]             tag_wcode,
	input  wire logic                          tag_rd_valid,
	input  wire logic [`L1P_TAG_W-1:0]         tag_rdata,
	input  wire logic [`L1P_CODE_W-1:0]        tag_rcode,
	output logic                               tag_ce,
	output logic                               tag_ue
);
	import l1_protect_pkg::*;

	// ****************************************
	// Code functions
	// ****************************************

	// Hamming checks at bits [k-1:0], overall parity at bit k
	function automatic logic [7:0] ham(input logic [63:0] d, input int nd);
		logic [6:0] h;
		logic [7:0] c;
		int         idx;
		int         pos;
		h = '0;
		idx = 0;
		for (pos = 3; pos < 72; pos++) begin
			if (((pos & (pos - 1)) != 0) && (idx < nd)) begin
				if (d[idx])
					h = h ^ pos[6:0];
				idx++;
			end
		end
		c = {1'b0, h};
		c[(nd == `L1P_E64_NBITS) ? 7 : 6] = ^d ^ ^h;
		return c;
	endfunction

	// A nonzero syndrome with odd overall parity is taken as single, right or not
	function automatic chk_t ham_chk(input logic [63:0] d, input logic [7:0] c, input int nd);
		logic [7:0] g;
		logic [7:0] m;
		logic [6:0] s;
		logic       op;
		int         idx;
		int         pos;
		chk_t       r;
		m = (nd == `L1P_E64_NBITS) ? 8'hFF : 8'h7F;
		g = ham(d, nd);
		s = (g[6:0] ^ c[6:0]) & m[7:1];
		op = ^d ^ ^(c & m);
		r.data = d;
		r.ce = op;
		r.ue = !op && (s != 7'h00);
		idx = 0;
		for (pos = 3; pos < 72; pos++) begin
			if (((pos & (pos - 1)) != 0) && (idx < nd)) begin
				if (op && (pos[6:0] == s))
					r.data[idx] = !d[idx];
				idx++;
			end
		end
		return r;
	endfunction

	function automatic logic [15:0] gen_code(input logic [63:0] d, input logic odd);
		logic [7:0]  lo;
		logic [7:0]  hi;
		logic [15:0] c;
		int          i;
		c = `L1P_RST_CODE;
		lo = ham({32'h0000_0000, d[31:0]}, `L1P_E32_NBITS);
		hi = ham({32'h0000_0000, d[63:32]}, `L1P_E32_NBITS);
		if (SCHEME == SCH_PARITY) begin
			for (i = 0; i < 8; i++)
				c[i] = ^d[8*i+:8] ^ odd;
		end else if (SCHEME == SCH_ECC32) begin
			c = {2'b00, hi[6:0], lo[6:0]};
		end else begin
			c = {8'h00, ham(d, `L1P_E64_NBITS)};
		end
		return c;
	endfunction

	function automatic chk_t chk_code(input logic [63:0] d, input logic [15:0] c, input logic odd);
		chk_t r;
		chk_t lo;
		chk_t hi;
		int   i;
		r = '{data: d, ce: 1'b0, ue: 1'b0};
		lo = ham_chk({32'h0000_0000, d[31:0]}, {1'b0, c[6:0]}, `L1P_E32_NBITS);
		hi = ham_chk({32'h0000_0000, d[63:32]}, {1'b0, c[13:7]}, `L1P_E32_NBITS);
		if (SCHEME == SCH_PARITY) begin
			for (i = 0; i < 8; i++)
				r.ue = r.ue | (^d[8*i+:8] ^ odd ^ c[i]);
		end else if (SCHEME == SCH_ECC32) begin
			r.data = {hi.data[31:0], lo.data[31:0]};
			r.ue = lo.ue | hi.ue;
			r.ce = (lo.ce | hi.ce) & !r.ue;
		end else begin
			r = ham_chk(d, c[7:0], `L1P_E64_NBITS);
		end
		return r;
	endfunction

	// Byte enables widened to the chunk grain of the scheme
	function automatic logic [7:0] chunk_be(input logic [7:0] be);
		if (SCHEME == SCH_PARITY)
			return be;
		else if (SCHEME == SCH_ECC32)
			return {{4{|be[7:4]}}, {4{|be[3:0]}}};
		return {8{|be}};
	endfunction

	function automatic logic [63:0] be_mask(input logic [7:0] be);
		logic [63:0] m;
		int          i;
		for (i = 0; i < 8; i++)
			m[8*i+:8] = {8{be[i]}};
		return m;
	endfunction

	// ****************************************
	// Datapath
	// ****************************************

	typedef enum logic [2:0] {ST_IDLE, ST_ACC, ST_CHK, ST_WAIT} state_t;

	state_t                 state_q, state_d;
	logic                   wr_q, wr_d;
	logic                   rmw_q, rmw_d;
	logic                   slave_q, slave_d;
	logic                   retried_q, retried_d;
	logic                   ce_seen_q, ce_seen_d;
	logic [3:0]             cnt_q, cnt_d;
	logic [7:0]             be_q, be_d;
	logic [63:0]            wdata_q, wdata_d;
	logic                   ram_en_d, ram_we_d;
	logic [7:0]             ram_be_d;
	logic [`L1P_ADDR_W-1:0] ram_addr_d;
	logic [63:0]            ram_wdata_d;
	logic [15:0]            ram_wcode_d;
	rsp_t                   rsp_d;
	chk_t                   rc_raw;
	chk_t                   rc;
	logic [63:0]            merged;
	logic                   full_cover;
	logic                   retry_go;

	// Checking is bypassed entirely while disabled
	assign rc_raw = chk_code(ram_rdata, ram_rcode, parity_odd);
	assign rc = check_en ? rc_raw : '{data: ram_rdata, ce: 1'b0, ue: 1'b0};
	assign merged = (wdata_q & be_mask(be_q)) | (rc.data & ~be_mask(be_q));
	assign full_cover = (chunk_be(req.be) == req.be);
	assign retry_go = rc.ce && correct_en && !slave_q && !retried_q && !ram_ext_err;
	assign req_ready = (state_q == ST_IDLE);

	// Sequencer: one RAM access in flight, read data one cycle after it
	always_comb begin
		state_d = state_q;
		wr_d = wr_q;
		rmw_d = rmw_q;
		slave_d = slave_q;
		retried_d = retried_q;
		ce_seen_d = ce_seen_q;
		cnt_d = cnt_q;
		be_d = be_q;
		wdata_d = wdata_q;
		ram_en_d = 1'b0;
		ram_we_d = 1'b0;
		ram_be_d = ram_be;
		ram_addr_d = ram_addr;
		ram_wdata_d = ram_wdata;
		ram_wcode_d = ram_wcode;
		rsp_d = rsp;
		rsp_d.valid = 1'b0;
		unique case (state_q)
			ST_IDLE: if (req.valid) begin
				wr_d = req.write;
				rmw_d = req.write && !full_cover;
				slave_d = req.from_slave;
				retried_d = 1'b0;
				ce_seen_d = 1'b0;
				be_d = req.be;
				wdata_d = req.wdata;
				ram_en_d = 1'b1;
				ram_we_d = req.write && full_cover;
				ram_be_d = req.write ? chunk_be(req.be) : 8'hFF;
				ram_addr_d = req.addr;
				ram_wdata_d = req.wdata;
				ram_wcode_d = gen_code(req.wdata, parity_odd);
				state_d = ST_ACC;
			end
			ST_ACC: state_d = ST_CHK;
			ST_CHK: begin
				if (rmw_q && !rc.ue && !ram_ext_err) begin
					rmw_d = 1'b0;
					ce_seen_d = rc.ce;
					ram_en_d = 1'b1;
					ram_we_d = 1'b1;
					ram_be_d = 8'hFF;
					ram_wdata_d = merged;
					ram_wcode_d = gen_code(merged, parity_odd);
					state_d = ST_ACC;
				end else if (!wr_q && retry_go) begin
					retried_d = 1'b1;
					ce_seen_d = 1'b1;
					ram_en_d = 1'b1;
					ram_we_d = 1'b1;
					ram_be_d = 8'hFF;
					ram_wdata_d = rc.data;
					ram_wcode_d = gen_code(rc.data, parity_odd);
					cnt_d = 4'(`L1P_RETRY_WAIT);
					state_d = ST_WAIT;
				end else begin
					rsp_d.valid = 1'b1;
					rsp_d.ext_err = ram_ext_err;
					rsp_d.uncorr_err = !(wr_q && !rmw_q) && rc.ue;
					// An uncorrectable read after a retry must not also claim a correction
					rsp_d.corr_err = !rsp_d.uncorr_err && (ce_seen_q || (!(wr_q && !rmw_q) && rc.ce));
					rsp_d.rdata = wr_q ? `L1P_RST_DATA : (correct_en ? rc.data : ram_rdata);
					state_d = ST_IDLE;
				end
			end
			ST_WAIT: begin
				// Re-read only after the gap, so the retry costs the full penalty
				if (cnt_q == 4'h0) begin
					ram_en_d = 1'b1;
					ram_be_d = 8'hFF;
					state_d = ST_ACC;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
		endcase
	end

	// Sequencer and RAM port registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ST_IDLE;
			{wr_q, rmw_q, slave_q, retried_q, ce_seen_q} <= 5'h00;
			cnt_q <= 4'h0;
			be_q <= 8'h00;
			wdata_q <= `L1P_RST_DATA;
			{ram_en, ram_we} <= 2'h0;
			ram_be <= 8'h00;
			ram_addr <= '0;
			ram_wdata <= `L1P_RST_DATA;
			ram_wcode <= `L1P_RST_CODE;
			rsp <= '0;
		end else begin
			state_q <= state_d;
			{wr_q, rmw_q, slave_q, retried_q, ce_seen_q} <= {wr_d, rmw_d, slave_d, retried_d, ce_seen_d};
			cnt_q <= cnt_d;
			be_q <= be_d;
			wdata_q <= wdata_d;
			{ram_en, ram_we} <= {ram_en_d, ram_we_d};
			ram_be <= ram_be_d;
			ram_addr <= ram_addr_d;
			ram_wdata <= ram_wdata_d;
			ram_wcode <= ram_wcode_d;
			rsp <= rsp_d;
		end
	end

	// ****************************************
	// Tag and dirty entries
	// ****************************************

	chk_t tag_rc;
	assign tag_rc = chk_code({{(64-`L1P_TAG_W){1'b0}}, tag_rdata}, tag_rcode, parity_odd);

	// Same code as the data, over the zero-extended entry
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tag_wcode <= `L1P_RST_CODE;
			{tag_ce, tag_ue} <= 2'h0;
		end else begin
			tag_wcode <= gen_code({{(64-`L1P_TAG_W){1'b0}}, tag_wdata}, parity_odd);
			tag_ce <= tag_rd_valid && check_en && tag_rc.ce;
			tag_ue <= tag_rd_valid && check_en && tag_rc.ue;
		end
	end

	// ****************************************
	// Checks
	// ****************************************

	chk_t wr_rc;
	assign wr_rc = chk_code(ram_wdata, ram_wcode, parity_odd);

	chk_written_code: assert property (@(posedge clk) disable iff (!rst_b)
		ram_we |-> !wr_rc.ce && !wr_rc.ue) else $error("stored code does not match stored data");
	chk_code_width: assert property (@(posedge clk) disable iff (!rst_b)
		ram_we |-> (SCHEME == SCH_ECC32) ? ram_wcode[15:14] == 2'b00 : ram_wcode[15:8] == 8'h00)
		else $error("unused code bits driven");
	chk_parity_nofix: assert property (@(posedge clk) disable iff (!rst_b)
		rsp.valid && (SCHEME == SCH_PARITY) |-> !rsp.corr_err) else $error("parity claimed a correction");
	chk_flag_split: assert property (@(posedge clk) disable iff (!rst_b)
		rsp.valid |-> !(rsp.corr_err && rsp.uncorr_err)) else $error("both error flags set");
	chk_read_turn: assert property (@(posedge clk) disable iff (!rst_b)
		req.valid && req_ready && !req.write |=> ram_en && !ram_we ##2 rsp.valid or ##11 rsp.valid)
		else $error("read answer out of time");
	chk_retry_gap: assert property (@(posedge clk) disable iff (!rst_b)
		state_q == ST_CHK && !wr_q && retry_go |=> ram_we ##1 (!ram_en && !rsp.valid)[*6] ##1 ram_en)
		else $error("retry write-back or gap wrong");
	chk_inline_fix: assert property (@(posedge clk) disable iff (!rst_b)
		state_q == ST_CHK && !wr_q && slave_q && rc.ce && correct_en |=> rsp.valid && rsp.rdata == $past(rc.data))
		else $error("slave read not corrected inline");
	chk_rmw_read: assert property (@(posedge clk) disable iff (!rst_b)
		req.valid && req_ready && req.write && !full_cover |=> ram_en && !ram_we ##2 (ram_we ^ rsp.valid))
		else $error("partial write skipped the read");
	chk_ext_report: assert property (@(posedge clk) disable iff (!rst_b)
		state_q == ST_CHK && ram_ext_err |=> rsp.valid && rsp.ext_err) else $error("external error lost");
	chk_check_off: assert property (@(posedge clk) disable iff (!rst_b)
		state_q == ST_CHK && !check_en && !ce_seen_q |=> !rsp.corr_err && !rsp.uncorr_err)
		else $error("flag raised while checking disabled");
endmodule

// ---- dv/ram_model.sv ----
// Behavioural RAM array for the protection block, with fault injection
`timescale 1ns/1ps
// ****************************
// RAM array model
// ****************************
module ram_model (
	input  wire logic        clk,
	input  wire logic        ram_en,
	input  wire logic        ram_we,
	input  wire logic [7:0]  ram_be,
	input  wire logic [15:0] ram_addr,
	input  wire logic [63:0] ram_wdata,
	input  wire logic [15:0] ram_wcode,
	input  wire logic        corrupt,
	input  wire logic [79:0] cor_mask,
	input  wire logic        fail_next,
	output logic [63:0]      ram_rdata,
	output logic [15:0]      ram_rcode,
	output logic             ram_ext_err
);
	logic [79:0] mem_q [16];
	logic [3:0]  wa;
	assign wa = ram_addr[3:0];
	// Read data is inverted on every cycle outside a read, so the stale word comes back on every second cycle
	always @(posedge clk) begin
		ram_ext_err <= ram_en & fail_next;
		if (ram_en && !ram_we) begin
			{ram_rcode, ram_rdata} <= mem_q[wa];
		end else begin
			{ram_rcode, ram_rdata} <= ~{ram_rcode, ram_rdata};
		end
		if (ram_en && ram_we) begin
			for (int i = 0; i < 8; i++) begin
				if (ram_be[i]) begin
					mem_q[wa][8*i +: 8] <= ram_wdata[8*i +: 8];
					mem_q[wa][64+i] <= ram_wcode[i];
				end
			end
			if (ram_be == 8'hFF) begin
				mem_q[wa][79:72] <= ram_wcode[15:8];
			end
		end
		// Soft errors are only planted in word 0, in any cycle with corrupt set, write or not
		if (corrupt) begin
			mem_q[0] <= mem_q[0] ^ cor_mask;
		end
	end
endmodule

// ---- dv/l1_ram_parity_ecc_protection_test.sv ----
// Self-checking bench for the L1 RAM protection block in all three protection schemes
`timescale 1ns/1ps
// ****************************
// Bench top
// ****************************
module l1_ram_parity_ecc_protection_test;
	import l1_protect_pkg::*;
	typedef struct {
		logic        wr;
		logic        slv;
		logic [7:0]  be;
		logic [15:0] a;
		logic [63:0] wd;
		logic [79:0] mask;
		logic [63:0] rd;
		logic        ce;
		logic        ue;
		int          lat;
	} row_t;
	localparam logic [63:0] DA = 64'h0123_4567_89AB_CDEF;
	localparam logic [63:0] DB = 64'hA5A5_5A5A_F00F_0FF0;
	logic        clk = 0;
	logic        rst_b = 0;
	logic        check_en = 1;
	logic        correct_en = 1;
	logic        corrupt = 0;
	logic        fail_next = 0;
	logic        tag_rd_valid = 0;
	logic [23:0] tag_wdata = 24'h5A_5A5A;
	logic [23:0] tag_flip = 0;
	logic [23:0] tf [3] = '{24'h0, 24'h1, 24'h3};
	logic [79:0] cor_mask = 0;
	req_t        req = '0;
	rsp_t        rsp;
	logic        req_ready, ram_en, ram_we, ram_ext_err, tag_ce, tag_ue;
	logic [7:0]  ram_be;
	logic [15:0] ram_addr, ram_wcode, ram_rcode, tag_wcode;
	logic [63:0] ram_wdata, ram_rdata;
	rsp_t        par_rsp, e32_rsp;
	logic        par_ram_en, par_ram_we, par_ram_ext_err, e32_ram_en, e32_ram_we, e32_ram_ext_err;
	logic [7:0]  par_ram_be, e32_ram_be;
	logic [15:0] par_ram_addr, par_ram_wcode, par_ram_rcode, e32_ram_addr, e32_ram_wcode, e32_ram_rcode;
	logic [63:0] par_ram_wdata, par_ram_rdata, e32_ram_wdata, e32_ram_rdata;
	int          mismatches = 0;
	int          checks_done = 0;
	// Plain cases: write, read, inject, read again
	row_t rows [11] = '{
		'{1, 0, 8'hFF, 0, DA, 0, 0, 0, 0, 3},
		'{0, 1, 8'hFF, 0, 0, 0, DA, 0, 0, 3},
		'{0, 1, 8'hFF, 0, 0, 80'h20, DA, 1, 0, 3},
		'{0, 0, 8'hFF, 0, 0, 0, DA, 1, 0, 12},
		'{0, 0, 8'hFF, 0, 0, 0, DA, 0, 0, 3},
		'{0, 1, 8'hFF, 0, 0, 80'h4_0000_0000_0000_0000, DA, 1, 0, 3},
		'{1, 0, 8'hFF, 0, DB, 0, 0, 0, 0, 3},
		'{0, 1, 8'hFF, 0, 0, 80'h8001, 0, 0, 1, 3},
		'{1, 0, 8'hFF, 1, DA, 0, 0, 0, 0, 3},
		'{1, 0, 8'h0F, 1, DB, 0, 0, 0, 0, 5},
		'{0, 1, 8'hFF, 1, 0, 0, {DA[63:32], DB[31:0]}, 0, 0, 3}
	};

	always #12.5 clk = ~clk;

	l1_ram_protect #(.SCHEME(SCH_ECC64)) l1_ram_protect_inst (
		.clk(clk), .rst_b(rst_b), .parity_odd(1'b0), .check_en(check_en), .correct_en(correct_en),
		.req(req), .req_ready(req_ready), .rsp(rsp), .ram_en(ram_en), .ram_we(ram_we), .ram_be(ram_be),
		.ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_wcode(ram_wcode), .ram_rdata(ram_rdata),
		.ram_rcode(ram_rcode), .ram_ext_err(ram_ext_err), .tag_wdata(tag_wdata), .tag_wcode(tag_wcode),
		.tag_rd_valid(tag_rd_valid), .tag_rdata(tag_wdata ^ tag_flip), .tag_rcode(tag_wcode),
		.tag_ce(tag_ce), .tag_ue(tag_ue));

	ram_model ram_model_inst (
		.clk(clk), .ram_en(ram_en), .ram_we(ram_we), .ram_be(ram_be), .ram_addr(ram_addr),
		.ram_wdata(ram_wdata), .ram_wcode(ram_wcode), .corrupt(corrupt), .cor_mask(cor_mask),
		.fail_next(fail_next), .ram_rdata(ram_rdata), .ram_rcode(ram_rcode), .ram_ext_err(ram_ext_err));

	// Parity (odd tie-off) and 32-bit code instances share the request and the fault lines
	l1_ram_protect #(.SCHEME(SCH_PARITY)) l1_ram_protect_par_inst (
		.clk(clk), .rst_b(rst_b), .parity_odd(1'b1), .check_en(check_en), .correct_en(correct_en),
		.req(req), .req_ready(), .rsp(par_rsp), .ram_en(par_ram_en), .ram_we(par_ram_we),
		.ram_be(par_ram_be), .ram_addr(par_ram_addr), .ram_wdata(par_ram_wdata), .ram_wcode(par_ram_wcode),
		.ram_rdata(par_ram_rdata), .ram_rcode(par_ram_rcode), .ram_ext_err(par_ram_ext_err),
		.tag_wdata(tag_wdata), .tag_wcode(), .tag_rd_valid(1'b0), .tag_rdata(tag_wdata),
		.tag_rcode(16'h0000), .tag_ce(), .tag_ue());

	ram_model ram_model_par_inst (
		.clk(clk), .ram_en(par_ram_en), .ram_we(par_ram_we), .ram_be(par_ram_be), .ram_addr(par_ram_addr),
		.ram_wdata(par_ram_wdata), .ram_wcode(par_ram_wcode), .corrupt(corrupt), .cor_mask(cor_mask),
		.fail_next(fail_next), .ram_rdata(par_ram_rdata), .ram_rcode(par_ram_rcode),
		.ram_ext_err(par_ram_ext_err));

	l1_ram_protect #(.SCHEME(SCH_ECC32)) l1_ram_protect_e32_inst (
		.clk(clk), .rst_b(rst_b), .parity_odd(1'b0), .check_en(check_en), .correct_en(correct_en),
		.req(req), .req_ready(), .rsp(e32_rsp), .ram_en(e32_ram_en), .ram_we(e32_ram_we),
		.ram_be(e32_ram_be), .ram_addr(e32_ram_addr), .ram_wdata(e32_ram_wdata), .ram_wcode(e32_ram_wcode),
		.ram_rdata(e32_ram_rdata), .ram_rcode(e32_ram_rcode), .ram_ext_err(e32_ram_ext_err),
		.tag_wdata(tag_wdata), .tag_wcode(), .tag_rd_valid(1'b0), .tag_rdata(tag_wdata),
		.tag_rcode(16'h0000), .tag_ce(), .tag_ue());

	ram_model ram_model_e32_inst (
		.clk(clk), .ram_en(e32_ram_en), .ram_we(e32_ram_we), .ram_be(e32_ram_be), .ram_addr(e32_ram_addr),
		.ram_wdata(e32_ram_wdata), .ram_wcode(e32_ram_wcode), .corrupt(corrupt), .cor_mask(cor_mask),
		.fail_next(fail_next), .ram_rdata(e32_ram_rdata), .ram_rcode(e32_ram_rcode),
		.ram_ext_err(e32_ram_ext_err));

	// ****************************
	// Helpers
	// ****************************
	task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tick();
		@(posedge clk);
		#1;
	endtask

	task automatic hit(logic [79:0] m);
		cor_mask = m;
		corrupt = 1;
		tick();
		corrupt = 0;
	endtask

	// One request, held for one cycle with ready checked, then timed to its answer
	task automatic access(logic wr, logic slv, logic [7:0] be, logic [15:0] a, logic [63:0] wd, int lat);
		int n;
		// The first cycle after the take is cycle one of the answer time
		n = 1;
		req = '{1'b1, wr, slv, be, a, wd};
		check("ready", req_ready, 1);
		tick();
		req.valid = 0;
		while (rsp.valid !== 1'b1 && n < 40) begin
			check("busy", req_ready, 0);
			tick();
			n++;
		end
		check("latency", n, lat);
	endtask

	task automatic flags(logic ce, logic ue, logic ee);
		check("corr_err", rsp.corr_err, ce);
		check("uncorr_err", rsp.uncorr_err, ue);
		check("ext_err", rsp.ext_err, ee);
	endtask

	task automatic conclude();
		if (mismatches == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Every RAM write of the 64-bit code instance is a whole doubleword with the spare code byte clear
	always @(posedge clk) begin
		if (ram_en === 1'b1 && ram_we === 1'b1) begin
			check("wr_be", ram_be, 8'hFF);
			check("code_hi", ram_wcode[15:8], 0);
		end
	end

	// Cut a hang short well beyond the expected hundred or so cycles
	initial begin
		#100000;
		mismatches++;
		conclude();
	end

	// ****************************
	// Main sequence
	// ****************************
	initial begin
		repeat (5) @(posedge clk);
		#1;
		check("rst_ready", req_ready, 1);
		check("rst_valid", rsp.valid, 0);
		check("rst_en", ram_en, 0);
		rst_b = 1;
		tick();
		foreach (rows[i]) begin
			if (rows[i].mask != 0) begin
				hit(rows[i].mask);
			end
			access(rows[i].wr, rows[i].slv, rows[i].be, rows[i].a, rows[i].wd, rows[i].lat);
			if (!rows[i].ue) begin
				check("rdata", rsp.rdata, rows[i].rd);
			end
			flags(rows[i].ce, rows[i].ue, 0);
		end
		// Correction off: flag raised, raw word returned, no retry
		access(1, 0, 8'hFF, 0, DA, 3);
		hit(80'h1);
		correct_en = 0;
		access(0, 0, 8'hFF, 0, 0, 3);
		check("raw", rsp.rdata, DA ^ 64'h1);
		flags(1, 0, 0);
		check_en = 0;
		access(0, 1, 8'hFF, 0, 0, 3);
		check("unchecked", rsp.rdata, DA ^ 64'h1);
		flags(0, 0, 0);
		check_en = 1;
		correct_en = 1;
		fail_next = 1;
		access(0, 1, 8'hFF, 1, 0, 3);
		flags(0, 0, 1);
		fail_next = 0;
		// Double error met during a merge aborts the write
		access(1, 0, 8'hFF, 0, DA, 3);
		hit(80'h3);
		access(1, 0, 8'h01, 0, DB, 3);
		flags(0, 1, 0);
		access(0, 1, 8'hFF, 0, 0, 3);
		flags(0, 1, 0);
		// Tag entries: clean, one flip, two flips
		foreach (tf[k]) begin
			tag_flip = tf[k];
			tag_rd_valid = 1;
			tick();
			tag_rd_valid = 0;
			check("tag_ce", tag_ce, k == 1);
			check("tag_ue", tag_ue, k == 2);
		end
		// Other schemes: slave reads only, so all three instances answer in the same cycle
		access(1, 1, 8'hFF, 0, DA, 3);
		for (int i = 0; i < 8; i++)
			check("par_code", par_ram_wcode[i], ~^DA[8*i+:8]);
		check("par_code_hi", par_ram_wcode[15:8], 0);
		check("e32_code_hi", e32_ram_wcode[15:14], 0);
		hit(80'h100_0000_0001);
		access(0, 1, 8'hFF, 0, 0, 3);
		flags(0, 1, 0);
		check("e32_valid", e32_rsp.valid, 1);
		check("e32_ce", e32_rsp.corr_err, 1);
		check("e32_ue", e32_rsp.uncorr_err, 0);
		check("e32_rdata", e32_rsp.rdata, DA);
		check("par_valid", par_rsp.valid, 1);
		check("par_ue", par_rsp.uncorr_err, 1);
		check("par_ce", par_rsp.corr_err, 0);
		access(1, 1, 8'hFF, 0, DA, 3);
		hit(80'h3);
		access(0, 1, 8'hFF, 0, 0, 3);
		flags(0, 1, 0);
		check("e32_ue2", e32_rsp.uncorr_err, 1);
		check("par_miss", par_rsp.uncorr_err, 0);
		check("par_raw", par_rsp.rdata, DA ^ 64'h3);
		// Reset in mid-access: the sequencer drops the access and comes back idle
		req = '{1'b1, 1'b0, 1'b1, 8'hFF, 16'h0001, 64'h0};
		tick();
		req.valid = 0;
		rst_b = 0;
		#1;
		check("mid_ready", req_ready, 1);
		check("mid_en", ram_en, 0);
		tick();
		rst_b = 1;
		tick();
		check("mid_valid", rsp.valid, 0);
		access(0, 1, 8'hFF, 1, 0, 3);
		check("mid_rdata", rsp.rdata, {DA[63:32], DB[31:0]});
		flags(0, 0, 0);
		conclude();
	end
endmodule
